// *** verification/bppp_board.sv ***
/* board model: pull-up level per pin, set by the bench.
   assumes oe_b low while the ports drive a pin. */
`timescale 1ns/1ps
module bppp_board (
  // pin side
  input wire logic [39:0] pin_out, pin_oe_b, ext_level,
  output logic [39:0] pin_in
);
  // driven pins follow the drive, released pins the board level
  assign pin_in = (pin_out & ~pin_oe_b) | (ext_level & pin_oe_b);
endmodule : bppp_board

// *** verification/bppp_checker.sv ***
/* checker for bppp_ports, bound after the module.
   assumes one clock and the default port width of eight. */
`timescale 1ns/1ps
module bppp_checker import bppp_pkg::*; (
  // clock, reset and bus
  input wire logic clk, rst_b,
  input wire bppp_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // pins and shared functions
  input wire logic [39:0] pin_in, pin_out, pin_oe_b, pin_level,
  input wire bppp_ssb_t sync_serial_b,
  input wire logic twowire_a_sel, twowire_b_sel,
  input wire logic [3:0] twowire_drive_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_inputs:
    assert property ($rose(rst_b) && !twowire_a_sel && !twowire_b_sel |-> &pin_oe_b[39:4])
    else $error("pin driven after reset");
  a_dir_drive:
    assert property (bus_req.wr && bus_req.addr == 8'h03 |=>
      pin_oe_b[15:8] == ~$past(bus_req.wdata)) else $error("direction not applied");
  a_latch_drive:
    assert property (bus_req.wr && bus_req.addr == 8'h02 |=> ((pin_out[15:8] ^
      $past(bus_req.wdata)) & ~pin_oe_b[15:8]) == 8'h00) else $error("latch not driven");
  a_read_mix:
    assert property (bus_req.rd && bus_req.addr == 8'h02 |=> bus_rdata == ($past(pin_out[15:8])
      & ~$past(pin_oe_b[15:8]) | $past(pin_level[15:8]) & $past(pin_oe_b[15:8])))
    else $error("read mix wrong");
  a_unmapped_zero:
    assert property (bus_req.rd && bus_req.addr > 8'h09 |=> bus_rdata == 8'h00)
    else $error("unmapped read");
  a_twa_open_drain:
    assert property (twowire_a_sel |-> pin_oe_b[19:18] == ~twowire_drive_low[1:0] &&
      (pin_out[19:18] & ~pin_oe_b[19:18]) == 2'h0) else $error("two-wire a drive");
  a_twb_open_drain:
    assert property (twowire_b_sel |-> pin_oe_b[21:20] == ~twowire_drive_low[3:2] &&
      (pin_out[21:20] & ~pin_oe_b[21:20]) == 2'h0) else $error("two-wire b drive");
  a_serial_share:
    assert property (|sync_serial_b.en |-> (pin_oe_b[3:0] & sync_serial_b.en) ==
      (~sync_serial_b.oe & sync_serial_b.en)) else $error("serial override");
endmodule : bppp_checker
bind bppp_ports bppp_checker i_bppp_checker (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
  .pin_level(pin_level), .sync_serial_b(sync_serial_b), .twowire_a_sel(twowire_a_sel),
  .twowire_b_sel(twowire_b_sel), .twowire_drive_low(twowire_drive_low));

// *** verification/bppp_ports_tb_top.sv ***
/* bench for bppp_ports with the board model on the pins.
   assumes register writes apply next cycle, read data one cycle late. */
`timescale 1ns/1ps
`define CHK(n,e,g) begin total_checks++; if ((g)!==(e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h",n,e,g); end end
module bppp_ports_tb_top import bppp_pkg::*; ;
  logic clk = 0, rst_b = 0, twowire_a_sel = 0, twowire_b_sel = 0;
  logic [3:0] twowire_drive_low = 4'h0;
  logic [39:0] ext_level = {40{1'b1}}, pin_in, pin_out, pin_oe_b, pin_level;
  logic [7:0] bus_rdata, q;
  bppp_req_t bus_req = '0;
  bppp_ssb_t sync_serial_b = '0;
  int miscompares = 0, total_checks = 0, cyc = 0;
  bppp_ports i_bppp_ports (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .sync_serial_b(sync_serial_b),
    .twowire_a_sel(twowire_a_sel), .twowire_b_sel(twowire_b_sel),
    .twowire_drive_low(twowire_drive_low), .pin_level(pin_level));
  bppp_board i_bppp_board (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_level(ext_level),
    .pin_in(pin_in));
  initial forever #5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) bus_req = '{1'b1, 1'b0, a, d};
    @(negedge clk) bus_req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk) bus_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) q = bus_rdata;
    bus_req = '0;
  endtask : rd
  task automatic t_pins();
    `CHK("oe_rst", {40{1'b1}}, pin_oe_b)
    ext_level[15:8] = 8'ha5;
    wr(8'h02, 8'h3c);
    wr(8'h03, 8'h5a);
    `CHK("oe1", 8'ha5, pin_oe_b[15:8])
    rd(8'h02);
    `CHK("rd1", 8'hbd, q)
    `CHK("lvl1", 8'hbd, pin_level[15:8])
    wr(8'h06, 8'h0f);
    `CHK("oe3", 8'hff, pin_oe_b[31:24])
    wr(8'h07, 8'hff);
    `CHK("out3", 8'h0f, pin_out[31:24])
    $display("done pins");
  endtask : t_pins
  task automatic t_shared();
    twowire_a_sel = 1;
    twowire_b_sel = 1;
    twowire_drive_low = 4'h5;
    sync_serial_b = '{4'hf, 4'h2, 4'ha};
    #1;
    `CHK("tw_oe", 4'ha, pin_oe_b[21:18])
    `CHK("ssb_oe", 4'h5, pin_oe_b[3:0])
    `CHK("ssb_out", 4'h2, pin_out[3:0])
    `CHK("tw_out", 4'h0, pin_out[21:18])
    twowire_a_sel = 0;
    twowire_b_sel = 0;
    wr(8'h04, 8'h34);
    wr(8'h05, 8'h3c);
    `CHK("tw_od", 4'h1, pin_oe_b[21:18])
    `CHK("tw_pp", 4'hc, pin_out[21:18])
    $display("done shared");
  endtask : t_shared
  task automatic t_map();
    for (int n = 0; n < 5; n++) wr(8'(2*n+1), 8'(8'h11*(n+1)));
    for (int n = 0; n < 5; n++) begin
      rd(8'(2*n+1));
      `CHK("dir", 8'(8'h11*(n+1)), q)
    end
    rd(8'h0a);
    `CHK("unmapped", 8'h00, q)
    $display("done map");
  endtask : t_map
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    t_pins();
    t_shared();
    t_map();
    close_out();
  end
endmodule : bppp_ports_tb_top

// *** verilog/bppp_pkg.sv ***
/*
  package for the byte-wide general purpose port block: register offsets,
  reset values and the shared carrier types.
  assumes a byte-wide cpu register bus with an address and one-cycle strobes.
*/
package bppp_pkg;
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DATA_BASE   = 8'h00; // port n data at 2n, direction at 2n+1
  // bit positions of shared functions
  localparam int unsigned SSB_RX_BIT  = 0;
  localparam int unsigned SSB_TX_BIT  = 1;
  localparam int unsigned SSB_CLK_BIT = 2;
  localparam int unsigned SSB_RDY_BIT = 3;
  localparam int unsigned TWA_LO_BIT  = 2;
  localparam int unsigned TWA_HI_BIT  = 3;
  localparam int unsigned TWB_LO_BIT  = 4;
  localparam int unsigned TWB_HI_BIT  = 5;
  localparam int unsigned SSB_PORT      = 0; // port that carries serial unit b
  localparam int unsigned TW_PORT       = 2; // port that carries both two-wire pairs
  localparam int unsigned TWB_DRIVE_IDX = 2; // first two-wire b bit of twowire_drive_low
  localparam logic [7:0]  RDATA_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_RDATA = 8'h00;

  // one register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } bppp_req_t;

  // peripheral override for one pin group: enable, drive value, output enable
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] val;
    logic [3:0] oe;
  } bppp_ssb_t;
endpackage : bppp_pkg

// *** verilog/bppp_ports.sv ***
/*
  five byte-wide general purpose ports with per-pin direction, output latches,
  direction-dependent read-back and shared-function overrides.
  assumes pins are resolved outside from out, oe_b (low while driving) and in.
*/
`timescale 1ns/1ps
module bppp_ports
  import bppp_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // cpu register bus
  input  wire bppp_req_t                   bus_req,
  output logic [7:0]                       bus_rdata,
  // pins: input level, output value, output enable (low drives)
  input  wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
  output logic [NUM_PORTS*PORT_W-1:0]      pin_out,
  output logic [NUM_PORTS*PORT_W-1:0]      pin_oe_b,
  // shared-function controls
  input  wire bppp_ssb_t                   sync_serial_b,
  input  wire logic                        twowire_a_sel,
  input  wire logic                        twowire_b_sel,
  input  wire logic [3:0]                  twowire_drive_low,
  // synchronised pin levels for the peripherals
  output logic [NUM_PORTS*PORT_W-1:0]      pin_level
);
  localparam int unsigned NB = NUM_PORTS*PORT_W;

  // pins are numbered port by port: bit 8n+k is port n bit k for the
  // default width, and every vector below follows that order

  // register state
  logic [NB-1:0]        latch_ff;
  logic [NB-1:0]        nxt_latch;
  logic [NB-1:0]        dir_ff;
  logic [NB-1:0]        nxt_dir;
  logic [7:0]           rdata_ff;
  logic [7:0]           nxt_rdata;
  // two-stage pin synchroniser
  logic [NB-1:0]        sync1_ff;
  logic [NB-1:0]        sync2_ff;
  // address decode and write strobes
  logic [ADDR_W-1:0]    rel_addr;
  logic                 in_range;
  logic                 sel_dir;
  logic [NUM_PORTS-1:0] port_hit;
  logic                 any_hit;
  logic [NUM_PORTS-1:0] latch_we;
  logic [NUM_PORTS-1:0] dir_we;
  // read-back views
  logic [NB-1:0]        read_view;
  logic [7:0]           data_view;
  logic [7:0]           dir_view;
  // driver stages, one per layer of override
  logic [NB-1:0]        base_val;
  logic [NB-1:0]        base_en;
  logic [NB-1:0]        ssb_val;
  logic [NB-1:0]        ssb_en;
  logic [NB-1:0]        twa_val;
  logic [NB-1:0]        twa_en;
  logic [NB-1:0]        drv_val;
  logic [NB-1:0]        drv_en;

  // address decode: port n data at base + 2n, direction at base + 2n + 1;
  // addresses below the base would wrap in the subtraction, so they are masked
  always_comb begin
    rel_addr = bus_req.addr - DATA_BASE;
    in_range = (bus_req.addr >= DATA_BASE);
    sel_dir  = rel_addr[0];
    port_hit = '0;
    for (int n = 0; n < NUM_PORTS; n++) begin
      if (in_range && rel_addr[ADDR_W-1:1] == (ADDR_W-1)'(n)) begin
        port_hit[n] = 1'h1;
      end
    end
    any_hit = |port_hit;
  end

  // write strobes: one per port for the latch and one for the direction byte;
  // a strobe outside the five ports raises neither
  always_comb begin
    latch_we = '0;
    dir_we   = '0;
    if (bus_req.wr) begin
      latch_we = sel_dir ? '0 : port_hit;
      dir_we   = sel_dir ? port_hit : '0;
    end
  end

  // next latch and direction values; unmapped writes change nothing.
  // a latch write lands regardless of direction, so an input pin keeps
  // the value ready for the moment it is turned to an output
  always_comb begin
    nxt_latch = latch_ff;
    nxt_dir   = dir_ff;
    for (int n = 0; n < NUM_PORTS; n++) begin
      if (latch_we[n]) begin
        nxt_latch[n*PORT_W +: PORT_W] = bus_req.wdata[PORT_W-1:0];
      end
      if (dir_we[n]) begin
        nxt_dir[n*PORT_W +: PORT_W] = bus_req.wdata[PORT_W-1:0];
      end
    end
  end

  // per-pin read view: output pins show the latch, input pins the
  // synchronised level, so a loaded output never reads back its own pad
  always_comb begin
    read_view = (latch_ff & dir_ff) | (sync2_ff & ~dir_ff);
  end

  // read mux: the addressed port's data and direction bytes;
  // unmapped addresses leave both views at the unmapped value
  always_comb begin
    data_view = UNMAPPED_RDATA;
    dir_view  = UNMAPPED_RDATA;
    for (int n = 0; n < NUM_PORTS; n++) begin
      if (port_hit[n]) begin
        data_view = 8'(read_view[n*PORT_W +: PORT_W]);
        dir_view  = 8'(dir_ff[n*PORT_W +: PORT_W]);
      end
    end
  end

  // read data: loads on a read strobe and holds until the next one;
  // a read and a write in one cycle return the value before the write
  always_comb begin
    nxt_rdata = rdata_ff;
    if (bus_req.rd) begin
      if (!any_hit) begin
        nxt_rdata = UNMAPPED_RDATA;
      end else if (sel_dir) begin
        nxt_rdata = dir_view;
      end else begin
        nxt_rdata = data_view;
      end
    end
  end

  // register state: latches, directions and read data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_ff <= {NUM_PORTS{LATCH_RESET[PORT_W-1:0]}};
      dir_ff   <= {NUM_PORTS{DIR_RESET[PORT_W-1:0]}};
      rdata_ff <= RDATA_RESET;
    end else begin
      latch_ff <= nxt_latch;
      dir_ff   <= nxt_dir;
      rdata_ff <= nxt_rdata;
    end
  end

  // two-stage synchroniser for the asynchronous pad levels; only the
  // second stage feeds logic, the first may still be metastable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // plain port drivers: direction one drives the latch, zero floats the pin;
  // the layers below may override these pin by pin
  always_comb begin
    base_val = latch_ff;
    base_en  = dir_ff;
  end

  // second synchronous serial unit: takes port zero bits zero to three
  // pin by pin, so unused serial pins stay ordinary port pins
  always_comb begin
    ssb_val = base_val;
    ssb_en  = base_en;
    for (int i = 0; i < $bits(sync_serial_b.en); i++) begin
      if (sync_serial_b.en[i]) begin
        ssb_val[SSB_PORT*PORT_W+SSB_RX_BIT+i] = sync_serial_b.val[i];
        ssb_en[SSB_PORT*PORT_W+SSB_RX_BIT+i]  = sync_serial_b.oe[i];
      end
    end
  end

  // port two bits two and three: low-only open-drain whatever the mode;
  // outside two-wire mode a zero in the latch pulls low on a direction-one pin, anything else releases
  always_comb begin
    twa_val = ssb_val;
    twa_en  = ssb_en;
    for (int i = TWA_LO_BIT; i <= TWA_HI_BIT; i++) begin
      twa_val[TW_PORT*PORT_W+i] = 1'h0;
      if (twowire_a_sel) begin
        twa_en[TW_PORT*PORT_W+i] = twowire_drive_low[i-TWA_LO_BIT];
      end else begin
        twa_en[TW_PORT*PORT_W+i] = dir_ff[TW_PORT*PORT_W+i] & ~latch_ff[TW_PORT*PORT_W+i];
      end
    end
  end

  // port two bits four and five: push-pull from the latch, switched to a
  // low-only driver while two-wire b owns them
  always_comb begin
    drv_val = twa_val;
    drv_en  = twa_en;
    for (int i = TWB_LO_BIT; i <= TWB_HI_BIT; i++) begin
      if (twowire_b_sel) begin
        drv_val[TW_PORT*PORT_W+i] = 1'h0;
        drv_en[TW_PORT*PORT_W+i]  = twowire_drive_low[TWB_DRIVE_IDX+i-TWB_LO_BIT];
      end
    end
  end

  // pad side: active-low enable, drive value and synchronised levels
  assign pin_out   = drv_val;
  assign pin_oe_b  = ~drv_en;
  assign pin_level = sync2_ff;

  // bus side: registered read data
  assign bus_rdata = rdata_ff;
endmodule : bppp_ports
